// file: bench/scb_link_model.sv
// Serial line partner: bit clock, frame sync, line data, output capture
`timescale 1ns/1ps
module scb_link_model (
   output scb_pkg::scb_pins_s pins,
   input wire logic [3:0] tx_data,
   input wire logic [3:0] tx_oe
);
   import scb_pkg::*;
   logic [3:0][31:0] cap;
   logic [3:0] oe_seen;
   initial begin
      pins = '0;
   end
   // ----------------------------------------
   // One frame: sync pulse, then n bits
   // ----------------------------------------
   // line clock and sync
   task automatic frame(input logic [31:0] w, input int n);
      int i;
      int k;
      cap = '0;
      oe_seen = '0;
      // Off the pclk edge so the input synchroniser never races the pins
      #1;
      // Both highways share one timing so every line select sees traffic
      pins.network_frame_sync = 1'h1;
      pins.serial_rx_frame_sync = 1'h1;
      pins.serial_tx_frame_sync = 1'h1;
      #24;
      pins.network_frame_sync = 1'h0;
      pins.serial_rx_frame_sync = 1'h0;
      pins.serial_tx_frame_sync = 1'h0;
      for (i = 0; i < n; i++) begin
         pins.du = w[31-i];
         pins.sr = w[31-i];
         #24;
         pins.dcl = 1'h1;
         pins.sclk = 1'h1;
         #24;
         pins.dcl = 1'h0;
         pins.sclk = 1'h0;
         for (k = 0; k < 4; k++) begin
            cap[k] = {cap[k][30:0], tx_data[k]};
         end
         oe_seen = oe_seen | tx_oe;
      end
      // Released line flips so a stale bit never looks valid
      pins.du = ~pins.du;
      pins.sr = ~pins.sr;
      // Clock stands still between frames
      #48;
   endtask : frame
endmodule : scb_link_model

// file: bench/scb_top_bench.sv
// Self-checking bench for the serial channel buffer block
`timescale 1ns/1ps
`include "scb_consts.svh"
module scb_top_bench;
   import scb_pkg::*;
   logic pclk = 1'h0;
   logic presetn = 1'h0;
   logic psel = 1'h0;
   logic penable = 1'h0;
   logic pwrite = 1'h0;
   logic [7:0] paddr = 8'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   scb_pins_s pins;
   scb_word_t [1:0] fr_tx_word = '0;
   scb_frx_s [1:0] fr_rx;
   logic [3:0] tx_data;
   logic [3:0] tx_oe;
   logic flag_req;
   logic [31:0] rdata;
   logic rerr;
   scb_word_t [1:0] fr_last = '0;
   int n_fail = 0;
   int n_checks = 0;

   always #2 pclk = ~pclk;

   scb_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .pins(pins), .fr_tx_word(fr_tx_word), .fr_rx(fr_rx),
      .tx_data(tx_data), .tx_oe(tx_oe), .flag_req(flag_req));

   scb_link_model LNK (.pins(pins), .tx_data(tx_data), .tx_oe(tx_oe));

   // Receiver feed words are one-cycle pulses
   always @(posedge pclk) begin
      for (int j = 0; j < 2; j++) begin
         if (fr_rx[j].valid === 1'h1) begin
            fr_last[j] <= fr_rx[j].word;
         end
      end
   end

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic tally_and_finish();
      $display("checks=%0d mismatches=%0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : tally_and_finish

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      for (k = 0; k < 40; k++) begin
         @(posedge pclk);
         if (pready === 1'h1) break;
      end
      chk({31'h0, pready}, 32'h1);
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'h1, a, d);
   endtask : wr

   task automatic rd(input logic [7:0] a);
      apb(1'h0, a, 32'h0);
   endtask : rd

   // Enabled channel, 8-bit count, slot of 8 bits at offset 0
   function automatic logic [31:0] cw(input logic [1:0] lm, input logic [1:0] ln,
      input logic s);
      cw = 32'h1 | (32'(lm) << `CF_LOAD_MODE_SELECT) | (32'h7 << `CF_LOAD_BIT_COUNT) | (32'(ln) << `CF_LINE)
         | (32'(s) << `CF_SRC) | (32'h7 << `CF_SLEN);
   endfunction : cw

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_regs();
      rd(`A_STAT);
      chk(rdata, 32'h0);
      rd(`A_MASK);
      chk(rdata, 32'h0);
      wr(8'h80, 32'h001FFFFE);
      rd(8'h80);
      chk(rdata, 32'h001FFFFE);
      wr(8'h80, 32'h0);
      wr(8'h00, 32'h1);
      chk({31'h0, rerr}, 32'h1);
      rd(8'hFC);
      chk({31'h0, rerr}, 32'h1);
      wr(8'h20, 32'hDEADBEEF);
      rd(8'h20);
      chk(rdata, 32'hDEADBEEF);
      rd(8'h60);
      chk(rdata, 32'h0);
   endtask : t_regs

   task automatic t_audio_rx();
      wr(`A_MASK, 32'h1);
      wr(8'h80, cw(2'h1, 2'h0, 1'h0));
      LNK.frame(32'h5A000000, 8);
      rd(8'h00);
      chk(rdata, 32'h5A);
      rd(8'h40);
      chk(rdata, 32'h5A);
      rd(`A_STAT);
      chk(rdata & 32'h1, 32'h1);
      #1;
      chk({31'h0, flag_req}, 32'h1);
      wr(`A_MASK, 32'h0);
      repeat (3) @(posedge pclk);
      #1;
      chk({31'h0, flag_req}, 32'h0);
      wr(`A_STAT, 32'h7FF);
      rd(`A_STAT);
      chk(rdata & 32'h1, 32'h0);
      wr(8'h80, 32'h0);
   endtask : t_audio_rx

   task automatic t_audio_sync();
      wr(8'h84, cw(2'h0, 2'h0, 1'h0));
      LNK.frame(32'hC6000000, 8);
      rd(8'h04);
      chk(rdata, 32'h0);
      wr(`A_STAT, 32'h7FF);
      LNK.frame(32'h0, 0);
      rd(8'h04);
      chk(rdata, 32'hC6);
      rd(`A_STAT);
      chk(rdata & 32'h102, 32'h102);
      wr(8'h84, 32'h0);
   endtask : t_audio_sync

   task automatic t_audio_tx();
      wr(8'h20, 32'hA5000000);
      wr(8'h60, 32'h3C000000);
      wr(`A_STAT, 32'h7FF);
      wr(8'h88, cw(2'h1, 2'h1, 1'h0));
      LNK.frame(32'h0, 8);
      rd(`A_STAT);
      chk(rdata & 32'h4, 32'h4);
      wr(8'h88, cw(2'h1, 2'h1, 1'h1));
      LNK.frame(32'h0, 8);
      chk({24'h0, LNK.cap[0][7:0]}, 32'hA5);
      chk({31'h0, LNK.oe_seen[0]}, 32'h1);
      LNK.frame(32'h0, 8);
      chk({24'h0, LNK.cap[0][7:0]}, 32'h3C);
      wr(8'h88, 32'h0);
   endtask : t_audio_tx

   task automatic t_framer_rx();
      wr(8'h28, 32'h11111111);
      wr(8'h68, 32'h22222222);
      wr(`A_STAT, 32'h7FF);
      wr(8'h90, cw(2'h0, 2'h0, 1'h0));
      LNK.frame(32'h96000000, 8);
      rd(8'h08);
      chk(rdata, 32'h96);
      rd(8'h48);
      chk(rdata, 32'h96);
      chk(fr_last[0], 32'h11111111);
      rd(`A_STAT);
      chk(rdata & 32'h10, 32'h10);
      wr(8'h90, cw(2'h0, 2'h0, 1'h1));
      LNK.frame(32'h3C000000, 8);
      chk(fr_last[0], 32'h22222222);
      wr(8'h90, 32'h0);
   endtask : t_framer_rx

   task automatic t_framer_tx();
      @(posedge pclk);
      fr_tx_word[0] <= 32'hC3000000;
      wr(8'h30, 32'h96000000);
      wr(`A_STAT, 32'h7FF);
      wr(8'h98, cw(2'h0, 2'h1, 1'h0));
      LNK.frame(32'h0, 8);
      rd(8'h10);
      chk(rdata, 32'hC3000000);
      rd(8'h50);
      chk(rdata, 32'hC3000000);
      rd(`A_STAT);
      chk(rdata & 32'h40, 32'h40);
      LNK.frame(32'h0, 8);
      chk({24'h0, LNK.cap[2][7:0]}, 32'h96);
      wr(8'h98, 32'h0);
   endtask : t_framer_tx

   task automatic t_audio_tx_sync();
      wr(8'h64, 32'h81000000);
      wr(8'h8C, cw(2'h0, 2'h0, 1'h1));
      LNK.frame(32'h0, 8);
      chk({24'h0, LNK.cap[1][7:0]}, 32'h81);
      rd(`A_STAT);
      chk(rdata & 32'h8, 32'h8);
      wr(8'h8C, 32'h0);
   endtask : t_audio_tx_sync

   // Serial rx line with 4-byte groups, serial tx line with 2-byte groups
   task automatic t_serial_lines();
      wr(8'h6C, 32'h0F0F0F0F);
      wr(8'h34, 32'hBEEF0000);
      @(posedge pclk);
      fr_tx_word[1] <= 32'h5AA55AA5;
      wr(`A_STAT, 32'h7FF);
      wr(8'h94, 32'h001F0607);
      wr(8'h9C, 32'h000F0305);
      LNK.frame(32'h12345678, 32);
      rd(8'h0C);
      chk(rdata, 32'h12345678);
      rd(8'h4C);
      chk(rdata, 32'h12345678);
      chk(fr_last[1], 32'h0F0F0F0F);
      rd(8'h14);
      chk(rdata, 32'h5AA55AA5);
      rd(`A_STAT);
      chk(rdata & 32'h6A0, 32'h6A0);
      LNK.frame(32'h0, 16);
      chk({16'h0, LNK.cap[3][15:0]}, 32'hBEEF);
      wr(8'h94, 32'h0);
      wr(8'h9C, 32'h0);
   endtask : t_serial_lines

   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'h1;
      t_regs();
      t_audio_rx();
      t_audio_sync();
      t_audio_tx();
      t_framer_rx();
      t_framer_tx();
      t_audio_tx_sync();
      t_serial_lines();
      tally_and_finish();
   end

   // Whole run needs about 8 us
   initial begin
      #100000;
      n_fail++;
      tally_and_finish();
   end
endmodule : scb_top_bench

// file: verilog/scb_chan.sv
// One serial channel: slot timing, 32-bit shifter, load strobe
`timescale 1ns/1ps
`include "scb_consts.svh"
module scb_chan #(
   parameter bit IS_TX = 1'b0
) (
   input wire logic pclk,
   input wire logic presetn,
   input scb_pkg::scb_ccfg_s cfg,
   input wire logic bit_stb,
   input wire logic sync_stb,
   input wire logic din,
   input scb_pkg::scb_word_t reload,
   output scb_pkg::scb_word_t shreg,
   output logic load,
   output logic dout,
   output logic doe
);
   import scb_pkg::*;
   scb_chan_st_s st_reg, st_next;
   logic in_slot, last;

   assign in_slot = (st_reg.pos >= {1'b0, cfg.offs}) &&
      (st_reg.pos <= 6'({1'b0, cfg.offs} + {1'b0, cfg.slen}));
   assign last = 6'(st_reg.cnt + 6'h01) == cfg.nbits;

   always_comb begin
      st_next = st_reg;
      st_next.load = 1'b0;
      // Sync wins over a coincident bit edge; slot count restarts
      if (sync_stb) begin
         st_next.pos = '0;
         if (cfg.en && cfg.fsmode) begin
            st_next.load = 1'b1;
            st_next.cnt = '0;
            if (IS_TX) begin
               st_next.sh = reload;
            end
         end
      end else if (bit_stb && cfg.en) begin
         if (st_reg.pos != `POS_MAX) begin
            st_next.pos = 6'(st_reg.pos + 6'h01);
         end
         st_next.doe = in_slot;
         if (in_slot) begin
            if (IS_TX) begin
               st_next.dout = st_reg.sh[31];
               st_next.sh = {st_reg.sh[30:0], 1'b0};
            end else begin
               st_next.sh = {st_reg.sh[30:0], din};
            end
            st_next.cnt = 6'(st_reg.cnt + 6'h01);
            if (!cfg.fsmode && last) begin
               st_next.load = 1'b1;
               st_next.cnt = '0;
               if (IS_TX) begin
                  st_next.sh = reload;
               end
            end
         end
      end
      if (!cfg.en) begin
         st_next.doe = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign shreg = st_reg.sh;
   assign load = st_reg.load;
   assign dout = st_reg.dout;
   assign doe = st_reg.doe;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   a_count_load: assert property (@(posedge pclk) disable iff (!presetn)
      bit_stb && !sync_stb && cfg.en && !cfg.fsmode && in_slot && last
      |=> load && st_reg.cnt == 6'h00)
      else $error("count reached without load");
   a_sync_load: assert property (@(posedge pclk) disable iff (!presetn)
      sync_stb && cfg.en && cfg.fsmode |=> load && st_reg.pos == 6'h00)
      else $error("frame sync load missing");
   a_no_idle_load: assert property (@(posedge pclk) disable iff (!presetn)
      !cfg.en |=> !load && !doe)
      else $error("disabled channel active");
endmodule : scb_chan

// file: verilog/scb_consts.svh
// Constants for the serial channel buffer block
`ifndef SCB_CONSTS_SVH
`define SCB_CONSTS_SVH
// ----------------------------------------
// Structure
// ----------------------------------------
`define N_CH 8
`define N_BUF 6
`define CFG_W 21
`define ST_W 11
// ----------------------------------------
// Address map
// ----------------------------------------
`define A_WR_BIT 5
`define A_HOST_BIT 6
`define A_CTL_BIT 7
`define A_STAT 8'hA0
`define A_MASK 8'hA4
// ----------------------------------------
// Channel config fields
// ----------------------------------------
`define CF_EN 0
`define CF_LOAD_MODE_SELECT 1
`define CF_LOAD_BIT_COUNT 3
`define CF_LINE 8
`define CF_SRC 10
`define CF_OFFS 11
`define CF_SLEN 16
// ----------------------------------------
// Status bits and counts
// ----------------------------------------
`define ST_AFULL0 0
`define ST_TEMPTY0 2
`define ST_RFS 9
`define FR_NB0 6'h08
`define FR_NB2 6'h10
`define FR_NB3 6'h20
`define POS_MAX 6'h3F
`endif

// file: verilog/scb_pkg.sv
// Types shared by the serial channel buffer block
`include "scb_consts.svh"
package scb_pkg;
   typedef logic [31:0] scb_word_t;
   typedef struct packed {
      logic dcl;
      logic network_frame_sync;
      logic sclk;
      logic serial_rx_frame_sync;
      logic serial_tx_frame_sync;
      logic du;
      logic dd;
      logic sr;
      logic st;
   } scb_pins_s;
   typedef struct packed {
      logic en;
      logic fsmode;
      logic [5:0] nbits;
      logic [4:0] offs;
      logic [4:0] slen;
   } scb_ccfg_s;
   typedef struct packed {
      scb_word_t word;
      logic valid;
   } scb_frx_s;
   typedef struct packed {
      scb_word_t sh;
      logic [5:0] cnt;
      logic [5:0] pos;
      logic load;
      logic dout;
      logic doe;
   } scb_chan_st_s;
   typedef struct packed {
      scb_pins_s p1;
      scb_pins_s p2;
      scb_pins_s p3;
      logic [1:0][`N_BUF-1:0][31:0] rd;
      logic [1:0][`N_BUF-1:0][31:0] wr;
      logic [`N_CH-1:0][`CFG_W-1:0] cfg;
      logic [`ST_W-1:0] stat;
      logic [`ST_W-1:0] mask;
      scb_word_t prdata;
      logic pready;
      logic pslverr;
      scb_frx_s [1:0] frx;
      logic flag_req;
   } scb_top_st_s;
endpackage : scb_pkg

// file: verilog/scb_top.sv
// Serial channel transfer buffers with APB register access
//
// The placing of the registers and register access over APB were decided locally.
`timescale 1ns/1ps
`include "scb_consts.svh"
module scb_top (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input scb_pkg::scb_pins_s pins,
   input scb_pkg::scb_word_t [1:0] fr_tx_word,
   output scb_pkg::scb_frx_s [1:0] fr_rx,
   output logic [3:0] tx_data,
   output logic [3:0] tx_oe,
   output logic flag_req
);
   import scb_pkg::*;
   scb_top_st_s st_reg, st_next;
   logic [`N_CH-1:0] ld;
   logic [`N_CH-1:0] dout;
   logic [`N_CH-1:0] doe;
   logic [`N_CH-1:0] src;
   scb_word_t [`N_CH-1:0] sh;
   logic [3:0] load_bit_count;
   logic [3:0] lsync;
   logic [3:0] ldat;
   logic iom_rise, sai_rise, fsc_rise;
   logic acc, first, wr_go, wr_stat;
   logic [2:0] bidx;
   logic [`ST_W-1:0] set;
   logic [`ST_W-1:0] clr;

   // ----------------------------------------
   // Line timing
   // ----------------------------------------
   // Edges taken from the second sync stage; p1 feeds p2 only
   assign iom_rise = st_reg.p2.dcl & ~st_reg.p3.dcl;
   assign sai_rise = st_reg.p2.sclk & ~st_reg.p3.sclk;
   assign fsc_rise = st_reg.p2.network_frame_sync & ~st_reg.p3.network_frame_sync;
   assign load_bit_count = {sai_rise, sai_rise, iom_rise, iom_rise};
   assign lsync = {st_reg.p2.serial_tx_frame_sync & ~st_reg.p3.serial_tx_frame_sync, st_reg.p2.serial_rx_frame_sync & ~st_reg.p3.serial_rx_frame_sync,
      fsc_rise, fsc_rise};
   assign ldat = {st_reg.p2.st, st_reg.p2.sr, st_reg.p2.dd, st_reg.p2.du};

   // ----------------------------------------
   // Channels
   // ----------------------------------------
   // 0-1 audio rx, 2-3 audio tx, 4-5 framer rx, 6-7 framer tx
   for (genvar c = 0; c < `N_CH; c++) begin : g_ch
      scb_ccfg_s cc;
      scb_word_t rl;
      logic [`CFG_W-1:0] cw;
      logic [1:0] ln;
      logic [1:0] lm;
      logic fsm;
      logic [5:0] nb;
      assign cw = st_reg.cfg[c];
      assign ln = cw[`CF_LINE +: 2];
      assign lm = cw[`CF_LOAD_MODE_SELECT +: 2];
      assign src[c] = cw[`CF_SRC];
      assign cc = {cw[`CF_EN], fsm, nb, cw[`CF_OFFS +: 5], cw[`CF_SLEN +: 5]};
      if (c < 4) begin : g_aud
         assign fsm = ~lm[0];
         assign nb = 6'({1'b0, cw[`CF_LOAD_BIT_COUNT +: 5]} + 6'h01);
      end else begin : g_frm
         assign fsm = 1'b0;
         assign nb = (lm == 2'b11) ? `FR_NB3 : (lm == 2'b10) ? `FR_NB2 : `FR_NB0;
      end
      if (c < 2) begin : g_norl
         assign rl = '0;
      end else begin : g_rl
         assign rl = st_reg.wr[src[c]][c-2];
      end
      scb_chan #(
         .IS_TX((c % 4) >= 2)
      ) u_chan (
         .pclk(pclk),
         .presetn(presetn),
         .cfg(cc),
         .bit_stb(load_bit_count[ln]),
         .sync_stb(lsync[ln]),
         .din(ldat[ln]),
         .reload(rl),
         .shreg(sh[c]),
         .load(ld[c]),
         .dout(dout[c]),
         .doe(doe[c])
      );
   end

   // ----------------------------------------
   // APB decode
   // ----------------------------------------
   // One wait state keeps every bus output registered
   assign acc = psel & penable;
   assign first = acc & ~st_reg.pready;
   assign wr_go = acc & st_reg.pready & pwrite & ~st_reg.pslverr;
   assign bidx = paddr[4:2];
   assign wr_stat = wr_go && (paddr == `A_STAT);
   assign clr = wr_stat ? pwdata[`ST_W-1:0] : '0;

   always_comb begin
      st_next = st_reg;
      st_next.p1 = pins;
      st_next.p2 = st_reg.p1;
      st_next.p3 = st_reg.p2;
      st_next.pready = first;
      if (first) begin
         st_next.prdata = '0;
         st_next.pslverr = 1'b0;
         if (!paddr[`A_CTL_BIT]) begin
            if (bidx >= 3'(`N_BUF)) begin
               st_next.pslverr = 1'b1;
            end else if (paddr[`A_WR_BIT]) begin
               st_next.prdata = st_reg.wr[paddr[`A_HOST_BIT]][bidx];
            end else begin
               st_next.prdata = st_reg.rd[paddr[`A_HOST_BIT]][bidx];
               st_next.pslverr = pwrite;
            end
         end else if (paddr == `A_STAT) begin
            st_next.prdata = 32'(st_reg.stat);
         end else if (paddr == `A_MASK) begin
            st_next.prdata = 32'(st_reg.mask);
         end else if (!paddr[`A_HOST_BIT] && !paddr[`A_WR_BIT]) begin
            st_next.prdata = 32'(st_reg.cfg[bidx]);
         end else begin
            st_next.pslverr = 1'b1;
         end
      end
      if (wr_go) begin
         if (!paddr[`A_CTL_BIT]) begin
            st_next.wr[paddr[`A_HOST_BIT]][bidx] = pwdata;
         end else if (paddr == `A_MASK) begin
            st_next.mask = pwdata[`ST_W-1:0];
         end else if (paddr != `A_STAT) begin
            st_next.cfg[bidx] = pwdata[`CFG_W-1:0];
         end
      end
      // ----------------------------------------
      // Buffer transfers
      // ----------------------------------------
      for (int i = 0; i < 2; i++) begin
         st_next.frx[i].valid = 1'b0;
         for (int s = 0; s < 2; s++) begin
            // audio rx, framer rx and framer tx copies to both sides
            if (ld[i]) begin
               st_next.rd[s][i] = sh[i];
            end
            if (ld[4+i]) begin
               st_next.rd[s][2+i] = sh[4+i];
            end
            if (ld[6+i]) begin
               st_next.rd[s][4+i] = fr_tx_word[i];
            end
         end
         if (ld[4+i]) begin
            st_next.frx[i].word = st_reg.wr[src[4+i]][2+i];
            st_next.frx[i].valid = 1'b1;
         end
      end
      set = {lsync[3], lsync[2], fsc_rise, ld};
      // set beats clear, mask gates request
      st_next.stat = (st_reg.stat & ~clr) | set;
      st_next.flag_req = |(st_next.stat & st_next.mask);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign prdata = st_reg.prdata;
   assign pready = st_reg.pready;
   assign pslverr = st_reg.pslverr;
   assign fr_rx = st_reg.frx;
   assign flag_req = st_reg.flag_req;
   assign tx_data = {dout[7], dout[6], dout[3], dout[2]};
   assign tx_oe = {doe[7], doe[6], doe[3], doe[2]};

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_apb_first;
      psel && penable && !pready;
   endsequence
   sequence s_apb_done;
      pready ##1 !pready;
   endsequence

   a_apb_one_wait: assert property (s_apb_first |=> s_apb_done)
      else $error("apb answer not after one wait");
   a_rx_both_sides: assert property (ld[0] |=>
      st_reg.rd[0][0] == $past(sh[0]) && st_reg.rd[1][0] == $past(sh[0]))
      else $error("rx copies differ");
   a_rx_full_flag: assert property (ld[1] |=> st_reg.stat[`ST_AFULL0+1])
      else $error("rx full flag not set");
   a_tx_empty_flag: assert property (ld[2] |=> st_reg.stat[`ST_TEMPTY0])
      else $error("tx empty flag not set");
   a_tx_src_pick: assert property (ld[3] |->
      sh[3] == $past(st_reg.wr[src[3]][1]))
      else $error("tx reload from wrong side");
   a_frx_feed: assert property (ld[4] |=>
      fr_rx[0].valid && fr_rx[0].word == $past(st_reg.wr[src[4]][2]) ##1 !fr_rx[0].valid)
      else $error("receiver input not fed");
   a_ftx_copy: assert property (ld[6] |-> sh[6] == $past(st_reg.wr[src[6]][4])
      ##1 st_reg.rd[1][4] == $past(fr_tx_word[0]))
      else $error("framer tx transfer wrong");
   a_flag_sticky: assert property (st_reg.stat[0] && !(wr_stat && pwdata[0])
      |=> st_reg.stat[0])
      else $error("flag lost without clear");
   a_sync_flag: assert property (lsync[2] |=> st_reg.stat[`ST_RFS])
      else $error("rx frame sync flag missing");
   a_req_gate: assert property (!(|(st_reg.stat & st_reg.mask)) |-> !flag_req)
      else $error("request without unmasked flag");
   a_req_raise: assert property (|(st_reg.stat & st_reg.mask) |-> flag_req)
      else $error("unmasked flag without request");
endmodule : scb_top
